/* hsq_pkg.sv */
// package: method codes, motion encodings and timing counts for the homing sequencer
package hsq_pkg;
	localparam int METHOD_W = 8;
	localparam logic [7:0] M27 = 8'h1B;
	localparam logic [7:0] M28 = 8'h1C;
	localparam logic [7:0] M29 = 8'h1D;
	localparam logic [7:0] M30 = 8'h1E;
	localparam logic [7:0] M31 = 8'h1F;
	localparam logic [7:0] M32 = 8'h20;
	localparam logic [7:0] M33 = 8'h21;
	localparam logic [7:0] M34 = 8'h22;
	// speed command encoding
	localparam logic [1:0] SPD_ZERO = 2'h0;
	localparam logic [1:0] SPD_LOW = 2'h1;
	localparam logic [1:0] SPD_HIGH = 2'h2;
	// deceleration time before the low-speed leg
	localparam int CLK_MHZ = 25;
	localparam int DECEL_US = 100;
	localparam int DECEL_CYC = DECEL_US * CLK_MHZ;
	localparam int DECEL_W = 16;
endpackage

/* hsq_edge.sv */
// synchroniser and single-shot edge detector for one input pin
`timescale 1ns/1ns
module hsq_edge
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// pin and results
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic sync_a;
	logic sync_b;
	logic prev;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	assign level = sync_b;
	assign rise = sync_b & ~prev;
	assign fall = ~sync_b & prev;

	property p_once;
		@(posedge ref_clk) disable iff (reset) rise |=> !rise;
	endproperty
	a_once: assert property (p_once)
		else $error("edge reported twice");
	property p_rise_seen;
		@(posedge ref_clk) disable iff (reset) $rose(pin) |-> ##2 rise;
	endproperty
	a_rise_seen: assert property (p_rise_seen)
		else $error("pin rise not reported");
	// the first flop was held low in reset, so a fall right after it is not seen
	property p_fall_seen;
		@(posedge ref_clk) disable iff (reset) ($fell(pin) && !$past(reset)) |-> ##2 fall;
	endproperty
	a_fall_seen: assert property (p_fall_seen)
		else $error("pin fall not reported");
endmodule // hsq_edge

/* hsq_seq.sv */
// homing sequencer for methods 27 to 34
//
// What this block does
// - method number selects the homing sequence 27-34
// - 27 off: high rev rise, decel, low fwd fall
// - 27 on: low forward, stop on fall
// - 27 limit: high fwd fall, decel, low rev rise
// - 28 off: rev rise, decel, fwd fall, rev rise
// - 28 on: low fwd fall, low rev rise
// - 28 limit: high fwd fall, decel, rev rise
// - 29 off: high rev fall, decel, fwd rise
// - 29 on: same as switch off
// - 29 limit: fwd rise, decel, rev fall, fwd rise
// - 30 off: rev fall, decel, fwd rise, rev fall
// - 30 on: same as switch off
// - 30 limit: high fwd rise, decel, rev fall
// - methods 31 and 32 are reserved
// - 33: reverse until first index pulse
// - 34: forward until first index pulse
`timescale 1ns/1ns
module hsq_seq
	import hsq_pkg::*;
#(
	parameter int DECEL_CYCLES = DECEL_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// controller side
	input wire logic [hsq_pkg::METHOD_W-1:0] method,
	input wire logic start,
	output logic busy,
	output logic done,
	output logic rejected,
	// motor side
	input wire logic home_sw,
	input wire logic rev_limit,
	input wire logic index_z,
	output logic [1:0] speed,
	output logic dir_fwd
);
	import hsq_pkg::*;

	if (DECEL_CYCLES < 1 || DECEL_CYCLES >= (1 << DECEL_W))
	begin : g_decel_range
		$error("DECEL_CYCLES out of range");
	end

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_LEG1 = 6'h02,
		S_DECEL = 6'h04,
		S_LEG2 = 6'h08,
		S_LEG3 = 6'h10,
		S_DONE = 6'h20
	} hsq_state_e;

	// a leg: speed, direction and the edge it waits for
	typedef struct packed {
		logic [1:0] spd;
		logic fwd;
		logic want_rise;
	} hsq_leg_s;

	hsq_state_e state;
	hsq_state_e next_state;
	logic [7:0] cur;
	logic limit_path;
	logic [DECEL_W-1:0] dcnt;
	hsq_leg_s leg1, leg2, leg3;
	logic has_leg3;
	logic home_lvl, home_rise, home_fall;
	logic lim_lvl, lim_rise;
	logic z_rise;

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	hsq_edge u_home (.ref_clk(ref_clk), .reset(reset), .pin(home_sw),
		.level(home_lvl), .rise(home_rise), .fall(home_fall));
	hsq_edge u_lim (.ref_clk(ref_clk), .reset(reset), .pin(rev_limit),
		.level(lim_lvl), .rise(lim_rise), .fall());
	hsq_edge u_z (.ref_clk(ref_clk), .reset(reset), .pin(index_z),
		.level(), .rise(z_rise), .fall());

	// ----------------------------------------------------------------
	// method decode
	// ----------------------------------------------------------------
	// while idle the legs follow the method on the bus, so the first leg is right at once
	wire [7:0] m_now = (state == S_IDLE) ? method : cur;
	// a limit path left over from the last run must not steer the next start
	wire lp_now = (state != S_IDLE) && limit_path;
	wire is_27 = (m_now == M27);
	wire is_28 = (m_now == M28);
	wire is_29 = (m_now == M29);
	wire is_30 = (m_now == M30);
	wire is_idx = (m_now == M33) || (m_now == M34);
	wire m_valid = (method >= M27 && method <= M30) || method == M33 || method == M34;
	wire m_reserved = (method == M31) || (method == M32);
	wire start_on = home_lvl;
	// first leg chosen at start; legs after decel depend on path
	wire first_slow = (method == M27 || method == M28) && start_on;

	always_comb
	begin
		leg1 = '{SPD_HIGH, 1'b0, 1'b1};
		leg2 = '{SPD_LOW, 1'b1, 1'b0};
		leg3 = '{SPD_LOW, 1'b0, 1'b1};
		has_leg3 = 1'b0;
		if (is_idx)
			leg1 = '{SPD_LOW, m_now == M34, 1'b1};
		else if (lp_now)
		begin
			// limit path: high forward search, decel, then low legs
			if (is_27 || is_28)
			begin
				leg1 = '{SPD_HIGH, 1'b1, 1'b0};
				leg2 = '{SPD_LOW, 1'b0, 1'b1};
			end
			else if (is_29)
			begin
				leg1 = '{SPD_HIGH, 1'b1, 1'b1};
				leg2 = '{SPD_LOW, 1'b0, 1'b0};
				leg3 = '{SPD_LOW, 1'b1, 1'b1};
				has_leg3 = 1'b1;
			end
			else
			begin
				leg1 = '{SPD_HIGH, 1'b1, 1'b1};
				leg2 = '{SPD_LOW, 1'b0, 1'b0};
			end
		end
		else if (is_27)
		begin
			leg1 = '{SPD_HIGH, 1'b0, 1'b1};
			leg2 = '{SPD_LOW, 1'b1, 1'b0};
		end
		else if (is_28)
		begin
			leg1 = '{SPD_HIGH, 1'b0, 1'b1};
			leg2 = '{SPD_LOW, 1'b1, 1'b0};
			leg3 = '{SPD_LOW, 1'b0, 1'b1};
			has_leg3 = 1'b1;
		end
		else if (is_29)
		begin
			leg1 = '{SPD_HIGH, 1'b0, 1'b0};
			leg2 = '{SPD_LOW, 1'b1, 1'b1};
		end
		else
		begin
			leg1 = '{SPD_HIGH, 1'b0, 1'b0};
			leg2 = '{SPD_LOW, 1'b1, 1'b1};
			leg3 = '{SPD_LOW, 1'b0, 1'b0};
			has_leg3 = 1'b1;
		end
	end

	wire leg1_hit = is_idx ? z_rise : (leg1.want_rise ? home_rise : home_fall);
	wire leg2_hit = leg2.want_rise ? home_rise : home_fall;
	wire leg3_hit = leg3.want_rise ? home_rise : home_fall;
	// limit only matters while searching reverse at high speed
	wire lim_hit = !limit_path && !is_idx && !leg1.fwd && leg1.spd == SPD_HIGH
		&& (lim_rise || lim_lvl);
	wire dec_end = (dcnt == '0);

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
				if (start && m_valid)
					next_state = first_slow ? S_LEG2 : S_LEG1;
			S_LEG1:
				if (lim_hit)
					next_state = S_LEG1;
				else if (leg1_hit)
					next_state = is_idx ? S_DONE : S_DECEL;
			S_DECEL:
				if (dec_end)
					next_state = S_LEG2;
			S_LEG2:
				if (leg2_hit)
					next_state = has_leg3 ? S_LEG3 : S_DONE;
			S_LEG3:
				if (leg3_hit)
					next_state = S_DONE;
			S_DONE:
				if (start && (m_valid || m_reserved))
					next_state = S_IDLE;
			default:
				next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			cur <= 8'h00;
			limit_path <= 1'b0;
		end
		else if (state == S_IDLE && start && m_valid)
		begin
			cur <= method;
			limit_path <= 1'b0;
		end
		else if (state == S_LEG1 && lim_hit)
			limit_path <= 1'b1;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			dcnt <= '0;
		else if (state != S_DECEL)
			dcnt <= DECEL_W'(DECEL_CYCLES - 1);
		else if (!dec_end)
			dcnt <= dcnt - 1'b1;
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			speed <= SPD_ZERO;
			dir_fwd <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			rejected <= 1'b0;
		end
		else
		begin
			busy <= (next_state != S_IDLE) && (next_state != S_DONE);
			done <= (next_state == S_DONE);
			rejected <= (state == S_IDLE || state == S_DONE) && start && m_reserved
				? 1'b1 : (start && m_valid ? 1'b0 : rejected);
			case (next_state)
				S_LEG1:
				begin
					speed <= leg1.spd;
					dir_fwd <= leg1.fwd;
				end
				S_LEG2:
				begin
					speed <= leg2.spd;
					dir_fwd <= leg2.fwd;
				end
				S_LEG3:
				begin
					speed <= leg3.spd;
					dir_fwd <= leg3.fwd;
				end
				default:
					speed <= SPD_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_done_still;
		@(posedge ref_clk) disable iff (reset) done |-> speed == SPD_ZERO;
	endproperty
	a_done_still: assert property (p_done_still)
		else $error("moving while done");
	property p_rsv_nomove;
		@(posedge ref_clk) disable iff (reset)
			((state == S_IDLE || state == S_DONE) && start && m_reserved)
			|=> (speed == SPD_ZERO && rejected && !busy);
	endproperty
	a_rsv_nomove: assert property (p_rsv_nomove)
		else $error("reserved method moved");
	property p_z33;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG1 && cur == M33) |-> !dir_fwd && speed == SPD_LOW;
	endproperty
	a_z33: assert property (p_z33)
		else $error("method 33 not slow reverse");
	property p_z34;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG1 && cur == M34) |-> dir_fwd && speed == SPD_LOW;
	endproperty
	a_z34: assert property (p_z34)
		else $error("method 34 not slow forward");
	property p_z_done;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG1 && is_idx && z_rise) |=> done && speed == SPD_ZERO;
	endproperty
	a_z_done: assert property (p_z_done)
		else $error("index did not finish");
	property p_decel;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG1 && !is_idx && !lim_hit && leg1_hit)
			|=> state == S_DECEL && speed == SPD_ZERO;
	endproperty
	a_decel: assert property (p_decel)
		else $error("no deceleration");
	property p_slow27;
		@(posedge ref_clk) disable iff (reset)
			(state == S_IDLE && start && method == M27 && home_lvl) |=> speed == SPD_LOW && dir_fwd;
	endproperty
	a_slow27: assert property (p_slow27)
		else $error("27 on not slow forward");
	property p_slow28;
		@(posedge ref_clk) disable iff (reset)
			(state == S_IDLE && start && method == M28 && home_lvl) |=> speed == SPD_LOW && dir_fwd;
	endproperty
	a_slow28: assert property (p_slow28)
		else $error("28 on not slow forward");
	property p_fast_start;
		@(posedge ref_clk) disable iff (reset)
			(state == S_IDLE && start && m_valid && !first_slow && method != M33 && method != M34)
			|=> speed == SPD_HIGH && !dir_fwd;
	endproperty
	a_fast_start: assert property (p_fast_start)
		else $error("search did not start high reverse");
	property p_start;
		@(posedge ref_clk) disable iff (reset)
			(state == S_IDLE && start && m_valid) |=> busy;
	endproperty
	a_start: assert property (p_start)
		else $error("valid method did not start");
	property p_limit;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG1 && lim_hit) |=> ##1 dir_fwd && speed == SPD_HIGH;
	endproperty
	a_limit: assert property (p_limit)
		else $error("limit did not turn forward");
	property p_leg3_28;
		@(posedge ref_clk) disable iff (reset)
			(state == S_LEG3 && cur == M28) |-> speed == SPD_LOW && !dir_fwd;
	endproperty
	a_leg3_28: assert property (p_leg3_28)
		else $error("28 last leg not slow reverse");
endmodule // hsq_seq

/* hsq_motor_model.sv */
// behavioural axis: motor position, home switch zone, reverse limit, index marks
`timescale 1ns/1ns
module hsq_motor_model
	import hsq_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// motion command
	input wire logic [1:0] speed,
	input wire logic dir_fwd,
	// bench preset of position
	input wire logic load,
	input wire logic signed [31:0] load_pos,
	// pins and position
	output logic home_sw,
	output logic rev_limit,
	output logic index_z,
	output int pos
);
	int step;
	// high moves four counts a cycle so a late stop shows as overshoot
	assign step = (speed === SPD_HIGH) ? 4 : ((speed === SPD_LOW) ? 1 : 0);
	assign home_sw = (pos >= 100) && (pos <= 139);
	assign rev_limit = (pos <= 20);
	assign index_z = ((pos % 64) == 0);
	always @(posedge ref_clk)
	begin
		if (load)
			pos <= load_pos;
		else if (dir_fwd)
			pos <= pos + step;
		else
			pos <= pos - step;
	end
endmodule // hsq_motor_model

/* hsq_seq_tb_top.sv */
// self-checking bench: homing methods against the axis model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module hsq_seq_tb_top;
	import hsq_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] method = 8'h00;
	logic start = 1'b0;
	logic load = 1'b1;
	int load_pos = 300;
	logic busy, done, rejected, home_sw, rev_limit, index_z, dir_fwd;
	logic [1:0] speed;
	int pos;
	int failures = 0;
	int n_compared = 0;
	hsq_seq #(.DECEL_CYCLES(4)) uut (.ref_clk(ref_clk), .reset(reset), .method(method),
		.start(start), .busy(busy), .done(done), .rejected(rejected), .home_sw(home_sw),
		.rev_limit(rev_limit), .index_z(index_z), .speed(speed), .dir_fwd(dir_fwd));
	hsq_motor_model axis (.ref_clk(ref_clk), .speed(speed), .dir_fwd(dir_fwd),
		.load(load), .load_pos(load_pos), .home_sw(home_sw), .rev_limit(rev_limit),
		.index_z(index_z), .pos(pos));
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge ref_clk);
		#1 method = m;
		start = 1'b1;
		@(posedge ref_clk);
		#1 start = 1'b0;
	endtask
	// preset the axis, let the synchronisers settle, then run one homing
	task automatic run_homing(input logic [7:0] m, input int p, input logic d,
		input int lo, input int hi);
		int i;
		if (done === 1'b1)
			pulse(M27);
		@(posedge ref_clk);
		#1 load = 1'b1;
		load_pos = p;
		repeat (5) @(posedge ref_clk);
		#1 load = 1'b0;
		pulse(m);
		`CHK("busy", 1'b1, busy)
		`CHK("rej_clear", 1'b0, rejected)
		for (i = 0; i < 3000 && done !== 1'b1; i++)
			@(posedge ref_clk);
		#1;
		`CHK("done", 1'b1, done)
		`CHK("busy_end", 1'b0, busy)
		`CHK("speed_end", SPD_ZERO, speed)
		`CHK("dir_end", d, dir_fwd)
		`CHK("stop_pos", 1'b1, (pos >= lo && pos <= hi))
		repeat (4) @(posedge ref_clk);
		#1 `CHK("held_pos", 1'b1, (pos >= lo && pos <= hi))
	endtask
	task automatic t_m27();
		run_homing(M27, 200, 1'b1, 140, 152);
		run_homing(M27, 120, 1'b1, 140, 152);
		run_homing(M27, 60, 1'b0, 127, 139);
	endtask
	task automatic t_m28();
		run_homing(M28, 200, 1'b0, 127, 139);
		run_homing(M28, 120, 1'b0, 127, 139);
		run_homing(M28, 60, 1'b0, 127, 139);
	endtask
	task automatic t_m29();
		run_homing(M29, 200, 1'b1, 100, 112);
		run_homing(M29, 120, 1'b1, 100, 112);
		run_homing(M29, 60, 1'b1, 100, 112);
	endtask
	task automatic t_m30();
		run_homing(M30, 200, 1'b0, 88, 99);
		run_homing(M30, 120, 1'b0, 88, 99);
		run_homing(M30, 60, 1'b0, 88, 99);
	endtask
	task automatic t_index();
		run_homing(M33, 90, 1'b0, 52, 64);
		run_homing(M34, 90, 1'b1, 128, 140);
	endtask
	// reserved codes: flag only, the axis must not move
	task automatic t_reserved(input logic [7:0] m);
		int p0;
		p0 = pos;
		pulse(m);
		repeat (3) @(posedge ref_clk);
		#1 `CHK("rejected", 1'b1, rejected)
		`CHK("busy_rsv", 1'b0, busy)
		`CHK("done_rsv", 1'b0, done)
		`CHK("speed_rsv", SPD_ZERO, speed)
		`CHK("pos_rsv", p0, pos)
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1 reset = 1'b0;
		t_m27();
		t_m28();
		t_m29();
		t_m30();
		t_index();
		// leave done first so 31 is refused from idle, then 32 straight from done
		pulse(M27);
		t_reserved(M31);
		run_homing(M34, 90, 1'b1, 128, 140);
		t_reserved(M32);
		tally_and_finish();
	end
	// generous ceiling of 60000 cycles: runs last well under a hundred cycles each
	initial
	begin
		#(40 * 60000);
		failures++;
		tally_and_finish();
	end
endmodule // hsq_seq_tb_top
